// ===== hw/ppp_core.sv
// file: parallel programming port engine with its memories
`timescale 1ns/1ps
module ppp_core
  import ppp_pkg::*;
#(
  parameter logic [7:0] SIG0   = SIG0_DEF,  // arbitrary
  parameter logic [7:0] SIG1   = SIG1_DEF,  // arbitrary
  parameter logic [7:0] SIG2   = SIG2_DEF,  // arbitrary
  parameter logic [7:0] CAL_1M = CAL_DEF,
  parameter logic [7:0] CAL_2M = CAL_DEF,
  parameter logic [7:0] CAL_4M = CAL_DEF,
  parameter logic [7:0] CAL_8M = CAL_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        prog_mode_i,
  input  wire logic        load_strobe_pin_i,
  input  wire logic        action_sel_lo_i,
  input  wire logic        action_sel_hi_i,
  input  wire logic        byte_select_high_i,
  input  wire logic        byte_select_extended_i,
  input  wire logic        page_load_strobe_i,
  input  wire logic        wr_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             data_oe_o,
  output logic             ready_busy_flag_o,
  output logic             page_buffer_ready_o,
  input  wire logic        osc_trim_load_i,
  input  wire logic [7:0]  osc_trim_val_i,
  output logic [7:0]       osc_trim_reg_o,
  output logic             keep_eeprom_fuse_o,
  output ppp_fuse_s        fuse_state_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // commands that drain the page buffer
  function automatic logic is_page_cmd(input logic [7:0] c);
    return (c == CMD_WFLASH) || (c == CMD_WEE);
  endfunction : is_page_cmd

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------

  ppp_state_e        state_reg, state_next;  // engine state
  logic [CNT_W-1:0]  cnt_reg, cnt_next;      // erase addr / wait
  logic [7:0]        cmd_reg, cmd_next;      // loaded command
  logic [ADDR_W-1:0] addr_reg, addr_next;    // loaded address
  logic [7:0]        dlo_reg, dlo_next;      // data low byte
  logic [7:0]        dhi_reg, dhi_next;      // data high byte
  ppp_fuse_s         nv_reg, nv_next;        // stored fuses/locks
  ppp_fuse_s         act_reg, act_next;      // fuses in effect
  logic [7:0]        dout_reg, dout_next;    // read data pins
  logic [7:0]        osc_reg, osc_next;      // oscillator trim
  logic              lprev_reg, lprev_next;  // load strobe history
  logic              wprev_reg, wprev_next;  // write strobe history
  logic              pprev_reg, pprev_next;  // page load history

  logic [WORD_W-1:0] flash_mem [FLASH_WORDS];  // flash array
  logic [7:0]        ee_mem [EE_BYTES];         // eeprom array

  logic               flash_we;   // flash write this cycle
  logic [FADDR_W-1:0] flash_wa;
  logic [WORD_W-1:0]  flash_wd;
  logic               ee_we;      // eeprom write this cycle
  logic [EADDR_W-1:0] ee_wa;
  logic [7:0]         ee_wd;

  logic        load_edge;    // rising edge of load strobe
  logic        wr_edge;      // falling edge of write strobe
  logic        pl_edge;      // rising edge of page load
  logic        locked;       // first lock bit programmed
  logic        keep_ee;      // keep fuse programmed
  logic [7:0]  rd_byte;      // read mux result
  logic [WORD_W-1:0] fl_word;
  ppp_word_s   push_word;    // entry into page buffer
  ppp_word_s   pop_word;     // entry out of page buffer
  logic        pop_valid;
  logic        pop_ready;
  logic [FADDR_W-1:0] pop_addr;

  // ------------------------------------------------------------
  // strobe decode
  // ------------------------------------------------------------

  // strobes count only inside programming mode
  assign load_edge = prog_mode_i & load_strobe_pin_i & ~lprev_reg;
  assign pl_edge   = prog_mode_i & page_load_strobe_i & ~pprev_reg;
  // write edges while busy fall through, never queued
  assign wr_edge   = prog_mode_i & ~wr_n_i & wprev_reg
                     & (state_reg == ST_IDLE);
  assign locked    = ~nv_reg.lock[LOCK1_BIT];
  // keep fuse is read from the stored copy, not the latched one
  assign keep_ee   = ~nv_reg.hi[KEEP_EE_BIT];

  // ------------------------------------------------------------
  // page buffer
  // ------------------------------------------------------------

  // address splits into word index and page
  assign push_word.idx  = addr_reg[IDX_W-1:0];
  assign push_word.page = addr_reg[IDX_W +: PAGE_W];
  assign push_word.data = {dhi_reg, dlo_reg};
  assign pop_addr       = {pop_word.page, pop_word.idx};

  // programmer sees page_buffer_ready_o; a full buffer drops pulses
  ppp_fifo #(
    .WIDTH ($bits(ppp_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_page_buf (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (pl_edge),
    .in_ready_o  (page_buffer_ready_o),
    .in_data_i   (push_word),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_word)
  );

  // ------------------------------------------------------------
  // read multiplexer
  // ------------------------------------------------------------

  assign fl_word = flash_mem[addr_reg[FADDR_W-1:0]];

  // read byte chosen by command and byte selects
  always_comb begin
    rd_byte = 8'h00;
    case (cmd_reg)
      CMD_RSIG: begin
        if (byte_select_high_i) begin
          // calibration bytes in the high half
          case (addr_reg[1:0])
            2'h0:    rd_byte = CAL_1M;
            2'h1:    rd_byte = CAL_2M;
            2'h2:    rd_byte = CAL_4M;
            default: rd_byte = CAL_8M;
          endcase
        end else begin
          // signature ignores the lock state
          case (addr_reg[1:0])
            2'h0:    rd_byte = SIG0;
            2'h1:    rd_byte = SIG1;
            2'h2:    rd_byte = SIG2;
            default: rd_byte = 8'h00;
          endcase
        end
      end
      CMD_RFUSE: begin
        // stored bytes, zero means programmed
        case ({byte_select_extended_i, byte_select_high_i})
          SEL_LOCK:    rd_byte = nv_reg.lock;
          SEL_FUSE_HI: rd_byte = nv_reg.hi;
          default:     rd_byte = nv_reg.lo;
        endcase
      end
      CMD_RFLASH: begin
        rd_byte = byte_select_high_i ? fl_word[15:8]
                                     : fl_word[7:0];
      end
      CMD_REE: begin
        rd_byte = ee_mem[addr_reg[EADDR_W-1:0]];
      end
      default: begin
        rd_byte = 8'h00;  // unknown command reads zero
      end
    endcase
  end

  // ------------------------------------------------------------
  // control next state
  // ------------------------------------------------------------

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cmd_next   = cmd_reg;
    addr_next  = addr_reg;
    dlo_next   = dlo_reg;
    dhi_next   = dhi_reg;
    nv_next    = nv_reg;
    act_next   = act_reg;
    dout_next  = dout_reg;
    osc_next   = osc_reg;
    lprev_next = load_strobe_pin_i;
    wprev_next = wr_n_i;
    pprev_next = page_load_strobe_i;
    flash_we   = 1'b0;
    flash_wa   = pop_addr;
    flash_wd   = pop_word.data;
    ee_we      = 1'b0;
    ee_wa      = pop_addr[EADDR_W-1:0];
    ee_wd      = pop_word.data[7:0];
    pop_ready  = 1'b0;

    // loads stay until replaced
    if (load_edge) begin
      case ({action_sel_hi_i, action_sel_lo_i})
        ACT_ADDR: begin
          if (byte_select_high_i) begin
            addr_next[15:8] = data_i;
          end else begin
            addr_next[7:0] = data_i;
          end
        end
        ACT_DATA: begin
          if (byte_select_high_i) begin
            dhi_next = data_i;
          end else begin
            dlo_next = data_i;
          end
        end
        ACT_CMD: begin
          cmd_next = data_i;
        end
        default: begin
          cmd_next = cmd_reg;  // idle code, nothing loaded
        end
      endcase
    end

    case (state_reg)
      ST_IDLE: begin
        // write strobe runs the loaded command
        if (wr_edge) begin
          case (cmd_reg)
            CMD_ERASE: begin
              state_next = ST_ERASE;
              cnt_next   = '0;
            end
            CMD_WFUSE: begin
              // first lock bit freezes the fuses
              if (!locked) begin
                if (byte_select_high_i) begin
                  nv_next.hi = data_i;
                end else begin
                  nv_next.lo = data_i;
                end
              end
              state_next = ST_WAIT;
              cnt_next   = PROG_CNT;
            end
            CMD_WLOCK: begin
              // lock bits only move toward programmed
              nv_next.lock = nv_reg.lock & data_i;
              state_next   = ST_WAIT;
              cnt_next     = PROG_CNT;
            end
            CMD_WFLASH, CMD_WEE: begin
              state_next = ST_PROG;
            end
            default: begin
              state_next = ST_IDLE;  // reads do nothing here
            end
          endcase
        end
      end
      ST_ERASE: begin
        // one word a cycle across the whole flash
        flash_we = 1'b1;
        flash_wa = cnt_reg[FADDR_W-1:0];
        flash_wd = ERASED_WORD;
        ee_wa    = cnt_reg[EADDR_W-1:0];
        ee_wd    = ERASED_BYTE;
        ee_we    = (cnt_reg < CNT_W'(EE_BYTES)) && !keep_ee;
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg == ERASE_LAST) begin
          // locks clear only once flash is blank
          nv_next.lock = LOCK_RST;
          state_next   = ST_IDLE;
        end
      end
      ST_PROG: begin
        // drain one buffered word per write time
        if (pop_valid) begin
          pop_ready  = 1'b1;
          flash_we   = (cmd_reg == CMD_WFLASH);
          ee_we      = (cmd_reg == CMD_WEE);
          state_next = ST_WAIT;
          cnt_next   = PROG_CNT;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (cnt_reg == '0) begin
          state_next = is_page_cmd(cmd_reg) ? ST_PROG : ST_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase

    // output strobe low executes the read; frozen while busy
    if (prog_mode_i && !oe_n_i && state_reg == ST_IDLE) begin
      dout_next = rd_byte;
    end

    // fuses in effect follow the store only outside programming
    if (!prog_mode_i) begin
      act_next = nv_reg;
    end

    // software may retrim for other frequencies
    if (osc_trim_load_i) begin
      osc_next = osc_trim_val_i;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      cmd_reg   <= 8'h00;
      addr_reg  <= '0;
      dlo_reg   <= 8'h00;
      dhi_reg   <= 8'h00;
      nv_reg    <= '{lock: LOCK_RST, hi: FUSE_HI_RST, lo: FUSE_LO_RST};
      act_reg   <= '{lock: LOCK_RST, hi: FUSE_HI_RST, lo: FUSE_LO_RST};
      dout_reg  <= 8'h00;
      osc_reg   <= CAL_1M;
      lprev_reg <= 1'b0;
      wprev_reg <= 1'b1;
      pprev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cmd_reg   <= cmd_next;
      addr_reg  <= addr_next;
      dlo_reg   <= dlo_next;
      dhi_reg   <= dhi_next;
      nv_reg    <= nv_next;
      act_reg   <= act_next;
      dout_reg  <= dout_next;
      osc_reg   <= osc_next;
      lprev_reg <= lprev_next;
      wprev_reg <= wprev_next;
      pprev_reg <= pprev_next;
    end
  end

  // ------------------------------------------------------------
  // memory arrays
  // ------------------------------------------------------------

  // contents survive reset like real cells
  always_ff @(posedge clk_i) begin
    if (flash_we) begin
      flash_mem[flash_wa] <= flash_wd;
    end
    if (ee_we) begin
      ee_mem[ee_wa] <= ee_wd;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------

  assign data_o             = dout_reg;
  // pins driven only while output strobe is low
  assign data_oe_o          = prog_mode_i & ~oe_n_i;
  assign ready_busy_flag_o  = (state_reg == ST_IDLE);
  assign osc_trim_reg_o     = osc_reg;
  assign keep_eeprom_fuse_o = nv_reg.hi[KEEP_EE_BIT];
  assign fuse_state_o       = act_reg;

endmodule : ppp_core

// ===== hw/ppp_pkg.sv
// package: constants and types of the parallel programming port
//
// Behaviour
// - fuse changes act only after leaving programming
// - eeprom keep fuse acts at once
// - three signature bytes always readable
// - four calibration bytes in signature high byte
// - 1 mhz calibration loaded at reset
// - action bits pick address, data, command, idle
// - byte select high picks low/high byte
// - write or output strobe runs loaded command
// - decode the five write command codes
// - decode the four read command codes
// - ready flag low while busy, high ready
// - data pins driven only while oe low
// - extended byte select picks second high byte
// - page load strobe fills page buffer
// - programmed fuse reads zero, unprogrammed one
// - command and address kept across operations
package ppp_pkg;

  // widths and sizes
  localparam int DATA_W      = 8;
  localparam int WORD_W      = 16;
  localparam int ADDR_W      = 16;
  localparam int FADDR_W     = 12;
  localparam int EADDR_W     = 9;
  localparam int IDX_W       = 5;   // 32 words a page
  localparam int PAGE_W      = 7;   // 128 pages
  localparam int FLASH_WORDS = 4096;
  localparam int EE_BYTES    = 512;
  localparam int FIFO_DEPTH  = 8;
  localparam int CNT_W       = 13;

  // action select codes {hi, lo}
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;

  // command bytes
  localparam logic [7:0] CMD_ERASE  = 8'h80;
  localparam logic [7:0] CMD_WFUSE  = 8'h40;
  localparam logic [7:0] CMD_WLOCK  = 8'h20;
  localparam logic [7:0] CMD_WFLASH = 8'h10;
  localparam logic [7:0] CMD_WEE    = 8'h11;
  localparam logic [7:0] CMD_RSIG   = 8'h08;
  localparam logic [7:0] CMD_RFUSE  = 8'h04;
  localparam logic [7:0] CMD_RFLASH = 8'h02;
  localparam logic [7:0] CMD_REE    = 8'h03;

  // {extended, high} selects on fuse reads
  localparam logic [1:0] SEL_LOCK    = 2'h1;
  localparam logic [1:0] SEL_FUSE_HI = 2'h3;

  // reset and erased values
  localparam logic [7:0]  FUSE_LO_RST  = 8'he1;
  localparam logic [7:0]  FUSE_HI_RST  = 8'hd9;
  localparam logic [7:0]  LOCK_RST     = 8'hff;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam int          KEEP_EE_BIT  = 3;
  localparam int          LOCK1_BIT    = 0;

  // identity and calibration defaults, values arbitrary
  localparam logic [7:0] SIG0_DEF = 8'h5a;
  localparam logic [7:0] SIG1_DEF = 8'h3c;
  localparam logic [7:0] SIG2_DEF = 8'h0f;
  localparam logic [7:0] CAL_DEF  = 8'h80;

  // timing: clock 25 ns, cell write time
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PROG_TIME_NS  = 2000;
  localparam int PROG_CYC =
    (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] PROG_CNT   = CNT_W'(PROG_CYC - 1);
  localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(FLASH_WORDS - 1);

  // engine states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ERASE = 4'h2,
    ST_PROG  = 4'h4,
    ST_WAIT  = 4'h8
  } ppp_state_e;

  // one page buffer entry
  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [IDX_W-1:0]  idx;
    logic [WORD_W-1:0] data;
  } ppp_word_s;

  // fuse and lock bytes as a bundle
  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] hi;
    logic [7:0] lo;
  } ppp_fuse_s;

endpackage : ppp_pkg

// ===== hw/ppp_fifo.sv
// file: page buffer fifo with valid/ready on both sides
`timescale 1ns/1ps
module ppp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  // storage; depth must be a power of two
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wp_reg, wp_next;  // extra bit tells full
  logic [PW:0]      rp_reg, rp_next;
  logic             push, pop;

  // honest flags from the pointers
  assign in_ready_o  = (wp_reg ^ rp_reg) != {1'b1, {PW{1'b0}}};
  assign out_valid_o = wp_reg != rp_reg;
  assign out_data_o  = mem[rp_reg[PW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer advance
  always_comb begin
    wp_next = wp_reg + (PW+1)'(push);
    rp_next = rp_reg + (PW+1)'(pop);
  end

  // pointer registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // data array, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_reg[PW-1:0]] <= in_data_i;
    end
  end
endmodule : ppp_fifo

// ===== test/ppp_core_checker.sv
// checker: port-level assertions on the programming port top
`timescale 1ns/1ps
module ppp_core_checker
  import ppp_pkg::*;
#(
  parameter logic [7:0] CAL_1M = CAL_DEF
) (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       prog_mode_i,
  input wire logic       page_load_strobe_i,
  input wire logic       wr_n_i,
  input wire logic       oe_n_i,
  input wire logic [7:0] data_o,
  input wire logic       data_oe_o,
  input wire logic       ready_busy_flag_o,
  input wire logic       page_buffer_ready_o,
  input wire logic [7:0] osc_trim_reg_o,
  input wire logic       keep_eeprom_fuse_o,
  input wire ppp_fuse_s  fuse_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // busy run length; a counter since the bound exceeds a repetition
  logic [12:0] busy_cnt_reg;
  logic [12:0] busy_cnt_next;
  always_comb begin
    busy_cnt_next = ready_busy_flag_o ? 13'h0 : busy_cnt_reg + 13'h1;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) busy_cnt_reg <= 13'h0;
    else busy_cnt_reg <= busy_cnt_next;
  end
  oe_follow_a: assert property (data_oe_o == (prog_mode_i && !oe_n_i))
    else $error("data enable wrong");
  reset_vals_a: assert property ($fell(reset_i) |->
    osc_trim_reg_o == CAL_1M && ready_busy_flag_o && page_buffer_ready_o)
    else $error("reset values wrong");
  fuse_hold_a: assert property (prog_mode_i && $past(prog_mode_i) |->
    $stable(fuse_state_o)) else $error("fuses changed in prog mode");
  keep_track_a: assert property (!prog_mode_i && !$past(prog_mode_i) |->
    keep_eeprom_fuse_o == fuse_state_o.hi[KEEP_EE_BIT]) else $error("keep fuse off");
  busy_bound_a: assert property (busy_cnt_reg <= 13'h1001)
    else $error("busy too long");
  read_freeze_a: assert property ($past(!ready_busy_flag_o) |-> $stable(data_o))
    else $error("read data moved while busy");
  busy_cause_a: assert property ($fell(ready_busy_flag_o) |->
    $past(prog_mode_i) && !$past(wr_n_i) && $past(wr_n_i, 2))
    else $error("busy without write strobe");
  buf_cause_a: assert property ($fell(page_buffer_ready_o) |->
    $past(page_load_strobe_i) && !$past(page_load_strobe_i, 2))
    else $error("buffer full without page load");
  cover property (busy_cnt_reg == 13'h0fff);
  cover property ($fell(page_buffer_ready_o));
  cover property (data_oe_o);
endmodule : ppp_core_checker

bind ppp_core ppp_core_checker #(.CAL_1M(CAL_1M)) u_ppp_core_checker (
  .clk_i, .reset_i, .prog_mode_i, .page_load_strobe_i, .wr_n_i, .oe_n_i, .data_o,
  .data_oe_o, .ready_busy_flag_o, .page_buffer_ready_o, .osc_trim_reg_o,
  .keep_eeprom_fuse_o, .fuse_state_o
);

// ===== test/ppp_prog_model.sv
// partner: external programmer driving strobes and the data pins
`timescale 1ns/1ps
module ppp_prog_model (
  input  wire logic       clk_i,
  input  wire logic       ready_i,
  input  wire logic [7:0] dev_data_i,
  output logic            load_o,
  output logic            sel_lo_o,
  output logic            sel_hi_o,
  output logic            bs_hi_o,
  output logic            bs_ext_o,
  output logic            pl_o,
  output logic            wr_n_o,
  output logic            oe_n_o,
  output logic [7:0]      data_o
);
  logic [7:0] drv;  // last byte driven
  // released bus shows the inverse, never a stale match
  assign data_o = oe_n_o ? drv : ~drv;
  // entry pins held at zero from the start
  initial begin
    {pl_o, sel_hi_o, sel_lo_o, bs_hi_o} = 4'h0;
    {load_o, bs_ext_o, wr_n_o, oe_n_o} = 4'h3;
    drv = 8'h00;
  end
  task automatic ld(input logic [1:0] act, input logic bs, input logic [7:0] v);
    @(posedge clk_i);
    {sel_hi_o, sel_lo_o} <= act;
    bs_hi_o <= bs;
    drv <= v;
    load_o <= 1'b1;
    @(posedge clk_i);
    load_o <= 1'b0;
    @(posedge clk_i);
  endtask : ld
  task automatic pl();
    @(posedge clk_i);
    pl_o <= 1'b1;
    @(posedge clk_i);
    pl_o <= 1'b0;
    @(posedge clk_i);
  endtask : pl
  // entry pins back to zero before programming mode is entered again
  task automatic ent();
    @(posedge clk_i);
    {pl_o, sel_hi_o, sel_lo_o, bs_hi_o} <= 4'h0;
    @(posedge clk_i);
  endtask : ent
  // write strobe, then count busy cycles until ready
  task automatic wr(input logic bs, output int busy);
    @(posedge clk_i);
    bs_hi_o <= bs;
    wr_n_o <= 1'b0;
    @(posedge clk_i);
    wr_n_o <= 1'b1;
    busy = 0;
    @(negedge clk_i);
    while (ready_i !== 1'b1 && busy < 5000) begin
      busy++;
      @(negedge clk_i);
    end
  endtask : wr
  task automatic rd(input logic bs, input logic ext, output logic [7:0] v);
    @(posedge clk_i);
    bs_hi_o <= bs;
    bs_ext_o <= ext;
    oe_n_o <= 1'b0;
    @(negedge clk_i);
    @(negedge clk_i);
    v = dev_data_i;
    @(posedge clk_i);
    oe_n_o <= 1'b1;
  endtask : rd
endmodule : ppp_prog_model

// ===== test/tb_parallel_program_port.sv
// testbench: programming port sequences with expected values
`timescale 1ns/1ps
module tb_parallel_program_port;
  import ppp_pkg::*;
  // signature bytes then calibration bytes, values arbitrary
  localparam logic [7:0] T [7] = '{8'h4b, 8'h72, 8'h19, 8'h91, 8'ha2, 8'hb3, 8'hc4};
  logic clk = 1'b0, reset_i = 1'b1, prog = 1'b0, tl = 1'b0;
  logic [7:0] tv = 8'h00, dout, din, v;
  logic doe, rdy, pbr, keep, ls, slo, shi, bsh, bse, plo, wrn, oen;
  logic [7:0] trim;
  ppp_fuse_s fst;
  int mismatches = 0, n_compared = 0, n;
  always #12.5 clk = ~clk;
  ppp_core #(.SIG0(T[0]), .SIG1(T[1]), .SIG2(T[2]), .CAL_1M(T[3]), .CAL_2M(T[4]),
    .CAL_4M(T[5]), .CAL_8M(T[6])) u_ppp_core (.clk_i(clk), .reset_i(reset_i),
    .prog_mode_i(prog), .load_strobe_pin_i(ls), .action_sel_lo_i(slo),
    .action_sel_hi_i(shi), .byte_select_high_i(bsh), .byte_select_extended_i(bse),
    .page_load_strobe_i(plo), .wr_n_i(wrn), .oe_n_i(oen), .data_i(din), .data_o(dout),
    .data_oe_o(doe), .ready_busy_flag_o(rdy), .page_buffer_ready_o(pbr),
    .osc_trim_load_i(tl), .osc_trim_val_i(tv), .osc_trim_reg_o(trim),
    .keep_eeprom_fuse_o(keep), .fuse_state_o(fst));
  ppp_prog_model u_ppp_prog_model (.clk_i(clk), .ready_i(rdy), .dev_data_i(dout),
    .load_o(ls), .sel_lo_o(slo), .sel_hi_o(shi), .bs_hi_o(bsh), .bs_ext_o(bse),
    .pl_o(plo), .wr_n_o(wrn), .oe_n_o(oen), .data_o(din));
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
    u_ppp_prog_model.ld(a, b, d);
  endtask : ld
  task automatic rchk(input string nm, input logic b, input logic e, input logic [7:0] x);
    u_ppp_prog_model.rd(b, e, v);
    chk(nm, v, x);
  endtask : rchk
  task automatic wr(input logic b);
    u_ppp_prog_model.wr(b, n);
  endtask : wr
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // hang guard, well above the longest sequence
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_i <= 1'b0;
    @(negedge clk);
    chk("trim", trim, T[3]);
    chk("ready", rdy, 1'b1);
    chk("fuses", fst, {LOCK_RST, FUSE_HI_RST, FUSE_LO_RST});
    @(posedge clk) prog <= 1'b1;
    // signature and calibration, command loaded once
    ld(ACT_CMD, 1'b0, CMD_RSIG);
    ld(ACT_ADDR, 1'b1, 8'h00);
    for (int i = 0; i < 7; i++) begin
      ld(ACT_ADDR, 1'b0, 8'(i < 3 ? i : i - 3));
      rchk("sig", i > 2, 1'b0, T[i]);
    end
    // idle action code must load nothing at all
    ld(2'h3, 1'b0, CMD_ERASE);
    rchk("idle load", 1'b1, 1'b0, T[6]);
    // fuse writes stay deferred except keep eeprom
    ld(ACT_CMD, 1'b0, CMD_WFUSE);
    ld(ACT_DATA, 1'b0, 8'hf7);
    wr(1'b1);
    chk("fuse busy", n, PROG_CYC);
    chk("keep", keep, 1'b0);
    chk("hi latched", fst.hi, FUSE_HI_RST);
    ld(ACT_DATA, 1'b0, 8'he4);
    wr(1'b0);
    ld(ACT_CMD, 1'b0, CMD_RFUSE);
    rchk("fuse hi", 1'b1, 1'b1, 8'hf7);
    rchk("fuse lo", 1'b0, 1'b0, 8'he4);
    @(posedge clk) prog <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk) chk("fuses", fst, {LOCK_RST, 8'hf7, 8'he4});
    u_ppp_prog_model.ent();
    @(posedge clk) prog <= 1'b1;
    // nine page loads into an eight deep buffer
    ld(ACT_CMD, 1'b0, CMD_WFLASH);
    ld(ACT_DATA, 1'b1, 8'h12);
    for (int i = 0; i < 9; i++) begin
      ld(ACT_ADDR, 1'b0, 8'h20 + 8'(i));
      ld(ACT_DATA, 1'b0, 8'(i));
      u_ppp_prog_model.pl();
    end
    chk("buf full", pbr, 1'b0);
    wr(1'b0);
    chk("buf empty", pbr, 1'b1);
    ld(ACT_CMD, 1'b0, CMD_RFLASH);
    for (int i = 0; i < 8; i++) begin
      ld(ACT_ADDR, 1'b0, 8'h20 + 8'(i));
      rchk("flash lo", 1'b0, 1'b0, 8'(i));
      rchk("flash hi", 1'b1, 1'b0, 8'h12);
    end
    // eeprom at top address
    ld(ACT_CMD, 1'b0, CMD_WEE);
    ld(ACT_ADDR, 1'b1, 8'h01);
    ld(ACT_ADDR, 1'b0, 8'hff);
    ld(ACT_DATA, 1'b0, 8'ha5);
    u_ppp_prog_model.pl();
    wr(1'b0);
    ld(ACT_CMD, 1'b0, CMD_REE);
    rchk("eeprom", 1'b0, 1'b0, 8'ha5);
    // chip erase with eeprom kept
    ld(ACT_CMD, 1'b0, CMD_ERASE);
    wr(1'b0);
    chk("erase busy", n, ERASE_LAST + 1);
    ld(ACT_CMD, 1'b0, CMD_REE);
    rchk("eeprom kept", 1'b0, 1'b0, 8'ha5);
    ld(ACT_CMD, 1'b0, CMD_RFLASH);
    ld(ACT_ADDR, 1'b1, 8'h00);
    ld(ACT_ADDR, 1'b0, 8'h20);
    rchk("erased", 1'b0, 1'b0, ERASED_BYTE);
    // locks after fuses, then fuses refuse writes
    ld(ACT_CMD, 1'b0, CMD_WLOCK);
    ld(ACT_DATA, 1'b0, 8'hfc);
    wr(1'b0);
    ld(ACT_CMD, 1'b0, CMD_WFUSE);
    ld(ACT_DATA, 1'b0, 8'h00);
    wr(1'b0);
    ld(ACT_CMD, 1'b0, CMD_RFUSE);
    rchk("lock", 1'b1, 1'b0, 8'hfc);
    rchk("fuse locked", 1'b0, 1'b0, 8'he4);
    ld(ACT_CMD, 1'b0, CMD_RSIG);
    ld(ACT_ADDR, 1'b0, 8'h02);
    rchk("sig locked", 1'b0, 1'b0, T[2]);
    // manual trim load for another frequency
    @(posedge clk);
    tl <= 1'b1;
    tv <= T[6];
    @(posedge clk) tl <= 1'b0;
    @(negedge clk) chk("trim load", trim, T[6]);
    results();
  end
endmodule : tb_parallel_program_port
